/* File: verilog/ppfs_port_pin_function_select.sv */
// Operation
// - D1 pin feeds capture when input, combo 00, selector_a, no PWM, io bit2.
// - Output enabled and combo 1x drives complementary PWM regardless of direction.
// - Output enabled and combo 01 drives reset-synchronous PWM.
// - Output enabled, combo 00, selector_a, PWM mode bit drives PWM waveform.
// - Output enabled, combo 00, selector_a, io field 001 or 01x drives compare.
// - Drive strength bit raises D1 drive while pin outputs.
// - Pull-up bit 5 serves D1 pin.
// - Pull-up bit 6 serves timer A, timer B, interrupt 2, data pins.
// - Pull-up bit 7 serves chip-select and serial clock pins.
// - Data pin output open-drain when its select bit set.
// - Chip-select output open-drain when its select bit set.
// - Clock pin output open-drain when its select bit set.
`timescale 1ns/1ps
module ppfs_port_pin_function_select
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire ppfs_pkg::ppfs_d1_cfg_s d1Cfg,
   input wire ppfs_pkg::ppfs_grp_cfg_s grpCfg,
   input wire logic portD1Data,
   input wire logic complPwm,
   input wire logic resyncPwm,
   input wire logic pwmWave,
   input wire logic compareWave,
   input wire logic timerAWave,
   input wire logic timerBWave,
   input wire logic [2:0] portGrpData,
   input wire logic serialDataOut,
   input wire logic serialCsOut,
   input wire logic serialClkOut,
   input wire logic twoWireSdaOut,
   input wire logic twoWireSclOut,
   input wire logic d1PinIn,
   input wire logic [5:0] grpPinIn,
   output logic d1PinOut,
   output logic d1PinOe,
   output logic d1PinPullup,
   output logic d1PinHighDrive,
   output logic d1Capture,
   output logic d1PortIn,
   output ppfs_pkg::ppfs_d1_mode_e d1Mode,
   output logic [5:0] grpPinOut,
   output logic [5:0] grpPinOe,
   output logic [5:0] grpPinPullup,
   output logic [5:0] grpPortIn,
   output logic int2Input,
   output logic serialDataIn,
   output logic serialCsIn,
   output logic serialClkIn,
   output logic twoWireSdaIn,
   output logic twoWireSclIn
);
   import ppfs_pkg::*;

   // ------------------------------------------------------------
   // Pin input synchronisers
   // ------------------------------------------------------------
   logic [6:0] pinSync;
   ppfs_sync #(.WIDTH(7)) u_sync
   (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .asyncIn({d1PinIn, grpPinIn}),
      .syncOut(pinSync)
   );

   // ------------------------------------------------------------
   // Channel D1 decode
   // ------------------------------------------------------------
   wire outEn = ~d1Cfg.chan_d1_output_disable;
   wire [1:0] cmb = {d1Cfg.combination_mode_hi, d1Cfg.combination_mode_lo};
   wire [2:0] iod = {d1Cfg.chan_d_io_ctrl_2, d1Cfg.chan_d_io_ctrl_1, d1Cfg.chan_d_io_ctrl_0};
   wire normSel = (cmb == PPFS_CMB_NORMAL) && d1Cfg.selector_a;
   wire selCompl = outEn && cmb[1];
   wire selResync = outEn && (cmb == PPFS_CMB_RESYNC);
   wire selPwm = outEn && normSel && d1Cfg.chan_d1_pwm_mode;
   wire selCmp = outEn && normSel && !d1Cfg.chan_d1_pwm_mode
      && (iod == PPFS_IOD_OC_LO || iod[2:1] == PPFS_IOD_OC_HI);
   wire selCap = !d1Cfg.p2_pin7_direction && normSel && !d1Cfg.chan_d1_pwm_mode && iod[2];
   ppfs_d1_mode_e modeNxt;
   assign modeNxt = selCompl ? PPFS_COMPL : selResync ? PPFS_RESYNC : selPwm ? PPFS_PWM
      : selCmp ? PPFS_COMPARE : selCap ? PPFS_CAPTURE
      : d1Cfg.p2_pin7_direction ? PPFS_GPIO_OUT : PPFS_GPIO_IN;
   logic d1OutNxt;
   logic d1OeNxt;
   always_comb
   begin
      d1OeNxt = 1'b1;
      case (modeNxt)
         PPFS_COMPL: d1OutNxt = complPwm;
         PPFS_RESYNC: d1OutNxt = resyncPwm;
         PPFS_PWM: d1OutNxt = pwmWave;
         PPFS_COMPARE: d1OutNxt = compareWave;
         PPFS_GPIO_OUT: d1OutNxt = portD1Data;
         default:
         begin
            d1OutNxt = 1'b0;
            d1OeNxt = 1'b0;
         end
      endcase
   end

   // ------------------------------------------------------------
   // Group decode
   // ------------------------------------------------------------
   wire iicMode = grpCfg.twoWireSel && grpCfg.twoWireEn;
   wire tbOut = (grpCfg.timerBMode != PPFS_TMOD_NONE) && !grpCfg.timerBOutCtl;
   wire dataOut = grpCfg.dataOutCtl && !grpCfg.dataInCtl && !grpCfg.twoWireSel;
   wire dataIn = !grpCfg.dataOutCtl && grpCfg.dataInCtl && !grpCfg.twoWireSel;
   wire csOut = grpCfg.csSel[1] && !grpCfg.twoWireSel;
   wire csIn = (grpCfg.csSel == PPFS_CS_INPUT) && !grpCfg.twoWireSel;
   wire clkSerMode = !grpCfg.twoWireSel && !grpCfg.twoWireEn;
   wire clkOut = grpCfg.clkOutCtl && !grpCfg.clkInCtl && clkSerMode;
   wire clkIn = !grpCfg.clkOutCtl && grpCfg.clkInCtl && clkSerMode;
   logic [5:0] gOeNxt;
   logic [5:0] gOutNxt;
   always_comb
   begin
      gOeNxt = grpCfg.dir;
      gOutNxt = {grpCfg.dir[5:3] & portGrpData, 3'h0};
      gOutNxt[2:0] = portGrpData;
      if (grpCfg.timerAOutEn)
      begin
         gOeNxt[0] = 1'b1;
         gOutNxt[0] = timerAWave;
      end
      if (tbOut)
      begin
         gOeNxt[1] = 1'b1;
         gOutNxt[1] = timerBWave;
      end
      gOutNxt[5:3] = portGrpData;
      if (dataOut)
      begin
         gOeNxt[3] = !grpCfg.data_pin_open_drain_sel || !serialDataOut;
         gOutNxt[3] = serialDataOut;
      end
      else if (dataIn)
         gOeNxt[3] = 1'b0;
      if (iicMode)
      begin
         gOeNxt[4] = !twoWireSdaOut;
         gOutNxt[4] = 1'b0;
      end
      else if (csOut)
      begin
         gOeNxt[4] = !grpCfg.chip_select_open_drain_sel || !serialCsOut;
         gOutNxt[4] = serialCsOut;
      end
      else if (csIn)
         gOeNxt[4] = 1'b0;
      if (iicMode)
      begin
         gOeNxt[5] = !twoWireSclOut;
         gOutNxt[5] = 1'b0;
      end
      else if (clkOut)
      begin
         gOeNxt[5] = !grpCfg.clock_pin_open_drain_sel || !serialClkOut;
         gOutNxt[5] = serialClkOut;
      end
      else if (clkIn)
         gOeNxt[5] = 1'b0;
   end
   // Port data for groups bits 3..5 uses portGrpData[2:0] as shared lanes
   // Bits 6 and 7 group pull-ups
   wire [5:0] puSel = {{2{grpCfg.pullup_ctrl_7}}, {4{grpCfg.pullup_ctrl_6}}};
   // Int2 pin is input only when enabled; pull-up stays per direction
   wire int2Sel = !grpCfg.dir[2] && grpCfg.int2En && grpCfg.int2Sel;

   // ------------------------------------------------------------
   // Output registers
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         d1Mode <= PPFS_GPIO_IN;
         d1PinOut <= PPFS_RST_LOW;
         d1PinOe <= PPFS_RST_LOW;
         d1PinPullup <= PPFS_RST_LOW;
         d1PinHighDrive <= PPFS_RST_LOW;
         d1Capture <= PPFS_RST_LOW;
         d1PortIn <= PPFS_RST_LOW;
         grpPinOut <= '0;
         grpPinOe <= '0;
         grpPinPullup <= '0;
         grpPortIn <= '0;
         int2Input <= PPFS_RST_LOW;
         serialDataIn <= PPFS_RST_LOW;
         serialCsIn <= PPFS_RST_LOW;
         serialClkIn <= PPFS_RST_LOW;
         twoWireSdaIn <= PPFS_RST_LOW;
         twoWireSclIn <= PPFS_RST_LOW;
      end
      else
      begin
         d1Mode <= modeNxt;
         d1PinOut <= d1OutNxt;
         d1PinOe <= d1OeNxt;
         d1PinPullup <= grpCfg.pullup_ctrl_5 && !d1OeNxt;
         d1PinHighDrive <= d1Cfg.p2_pin7_drive_strength && d1OeNxt;
         d1Capture <= selCap & pinSync[6];
         d1PortIn <= pinSync[6];
         grpPinOut <= gOutNxt;
         grpPinOe <= gOeNxt;
         grpPinPullup <= puSel & ~gOeNxt;
         grpPortIn <= pinSync[5:0];
         int2Input <= int2Sel & pinSync[2];
         serialDataIn <= dataIn & pinSync[3];
         serialCsIn <= csIn & pinSync[4];
         serialClkIn <= clkIn & pinSync[5];
         twoWireSdaIn <= iicMode & pinSync[4];
         twoWireSclIn <= iicMode & pinSync[5];
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   compl_drive_a: assert property (selCompl |=> d1PinOe && d1PinOut == $past(complPwm))
      else $error("compl pwm not driven");
   resync_drive_a: assert property (selResync |=> d1Mode == PPFS_RESYNC)
      else $error("resync pwm not selected");
   pwm_drive_a: assert property (selPwm && !selCompl && !selResync |=> d1Mode == PPFS_PWM)
      else $error("pwm mode not selected");
   cmp_drive_a: assert property (selCmp |=> d1PinOe)
      else $error("compare not driven");
   capture_route_a: assert property (selCap && !outEn |=> d1Capture == $past(pinSync[6]))
      else $error("capture not routed");
   gpio_dir_a: assert property (!outEn |=> d1PinOe == $past(d1Cfg.p2_pin7_direction))
      else $error("gpio direction wrong");
   high_drive_a: assert property (d1PinHighDrive |-> d1PinOe)
      else $error("high drive on input");
   pullup_input_a: assert property ((grpPinPullup & grpPinOe) == 6'h00)
      else $error("pullup on output");
   d1_pullup_a: assert property (d1PinPullup |-> !d1PinOe)
      else $error("d1 pullup on output");
   cs_od_a: assert property (csOut && !iicMode && grpCfg.chip_select_open_drain_sel
      && serialCsOut |=> !grpPinOe[4])
      else $error("cs not open drain");
   clk_od_a: assert property (clkOut && grpCfg.clock_pin_open_drain_sel
      && serialClkOut |=> !grpPinOe[5])
      else $error("clk not open drain");
   data_od_a: assert property (dataOut && grpCfg.data_pin_open_drain_sel
      && serialDataOut |=> !grpPinOe[3])
      else $error("data not open drain");
   cov_compl_c: cover property (selCompl ##1 d1PinOe);
   cov_capture_c: cover property (selCap ##1 d1Capture);
   cov_iic_c: cover property (iicMode ##1 twoWireSclIn);
   cov_od_c: cover property (dataOut && grpCfg.data_pin_open_drain_sel);
endmodule : ppfs_port_pin_function_select

/* File: verilog/ppfs_pkg.sv */
package ppfs_pkg;
   // ------------------------------------------------------------
   // Field values
   // ------------------------------------------------------------
   localparam logic [1:0] PPFS_CMB_NORMAL = 2'h0;
   localparam logic [1:0] PPFS_CMB_RESYNC = 2'h1;
   localparam logic [2:0] PPFS_IOD_OC_LO = 3'h1;
   localparam logic [1:0] PPFS_IOD_OC_HI = 2'h1;
   localparam logic [1:0] PPFS_CS_INPUT = 2'h1;
   localparam logic [1:0] PPFS_TMOD_NONE = 2'h0;
   localparam logic PPFS_RST_LOW = 1'h0;
   localparam int PPFS_SYNC_STAGES = 2;

   typedef enum {PPFS_GPIO_IN, PPFS_GPIO_OUT, PPFS_CAPTURE, PPFS_COMPL,
      PPFS_RESYNC, PPFS_PWM, PPFS_COMPARE} ppfs_d1_mode_e;

   // ------------------------------------------------------------
   // Configuration carrier
   // ------------------------------------------------------------
   typedef struct packed {
      logic p2_pin7_direction;
      logic chan_d1_output_disable;
      logic combination_mode_hi;
      logic combination_mode_lo;
      logic selector_a;
      logic chan_d1_pwm_mode;
      logic chan_d_io_ctrl_2;
      logic chan_d_io_ctrl_1;
      logic chan_d_io_ctrl_0;
      logic p2_pin7_drive_strength;
   } ppfs_d1_cfg_s;

   typedef struct packed {
      logic [5:0] dir;          // 0 TRA,1 TRB,2 INT2,3 data,4 cs,5 clk
      logic timerAOutEn;
      logic [1:0] timerBMode;
      logic timerBOutCtl;
      logic int2En;
      logic int2Sel;
      logic dataOutCtl;
      logic dataInCtl;
      logic [1:0] csSel;
      logic clkOutCtl;
      logic clkInCtl;
      logic twoWireSel;
      logic twoWireEn;
      logic data_pin_open_drain_sel;
      logic chip_select_open_drain_sel;
      logic clock_pin_open_drain_sel;
      logic pullup_ctrl_5;
      logic pullup_ctrl_6;
      logic pullup_ctrl_7;
   } ppfs_grp_cfg_s;
endpackage : ppfs_pkg

/* File: verilog/ppfs_sync.sv */
`timescale 1ns/1ps
module ppfs_sync
#(
   parameter int WIDTH = 1
)
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic [WIDTH-1:0] asyncIn,
   output logic [WIDTH-1:0] syncOut
);
   import ppfs_pkg::*;
   logic [WIDTH-1:0] meta_r;
   // Only the second stage is ever read
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         meta_r <= '0;
         syncOut <= '0;
      end
      else
      begin
         meta_r <= asyncIn;
         syncOut <= meta_r;
      end
   end
endmodule : ppfs_sync

/* File: testbench/ppfs_board_model.sv */
`timescale 1ns/1ps
module ppfs_board_model
(
   input wire logic sys_clk,
   input wire logic [6:0] pinOut,
   input wire logic [6:0] pinOe,
   input wire logic [6:0] pinPullup,
   input wire logic [6:0] extEn,
   input wire logic [6:0] extVal,
   output logic [6:0] pinLevel
);
   // ----------------------------
   // Pin resolution
   // ----------------------------
   // Floating pins wander, so a missing pull-up never reads as a clean level
   logic [6:0] floatVal;
   always_ff @(posedge sys_clk)
   begin
      floatVal <= (floatVal === 7'h55) ? 7'h2A : 7'h55;
   end
   always_comb
   begin
      for (int i = 0; i < 7; i++)
      begin
         if (pinOe[i])
            pinLevel[i] = pinOut[i];
         else if (extEn[i])
            pinLevel[i] = extVal[i];
         else if (pinPullup[i])
            pinLevel[i] = 1'h1;
         else
            pinLevel[i] = floatVal[i];
      end
   end
endmodule : ppfs_board_model

/* File: testbench/port_pin_function_select_tb.sv */
`timescale 1ns/1ps
module port_pin_function_select_tb;
   import ppfs_pkg::*;
   logic sys_clk, sys_rst;
   ppfs_d1_cfg_s d1Cfg;
   ppfs_grp_cfg_s grpCfg;
   logic portD1Data, complPwm, resyncPwm, pwmWave, compareWave, timerAWave, timerBWave;
   logic serialDataOut, serialCsOut, serialClkOut;
   logic d1PinOut, d1PinOe, d1PinPullup, d1PinHighDrive, d1Capture, d1PortIn;
   ppfs_d1_mode_e d1Mode;
   logic [5:0] grpPinOut, grpPinOe, grpPinPullup;
   logic [6:0] pinLevel, extEn, extVal;
   logic [2:0] portGrpData;
   logic twoWireSdaOut, twoWireSclOut;
   logic [5:0] grpPortIn;
   logic int2Input, serialDataIn, serialCsIn, serialClkIn, twoWireSdaIn, twoWireSclIn;
   int seed = 76232;
   int failures = 0;
   int comparisons = 0;
   int cycles = 0;
   logic [9:0] corner [10] = '{10'h100, 10'h301, 10'h028, 10'h281, 10'h0C0, 10'h240,
      10'h031, 10'h022, 10'h024, 10'h026};

   ppfs_port_pin_function_select dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .d1Cfg(d1Cfg),
      .grpCfg(grpCfg), .portD1Data(portD1Data), .complPwm(complPwm), .resyncPwm(resyncPwm),
      .pwmWave(pwmWave), .compareWave(compareWave), .timerAWave(timerAWave),
      .timerBWave(timerBWave), .portGrpData(portGrpData), .serialDataOut(serialDataOut),
      .serialCsOut(serialCsOut), .serialClkOut(serialClkOut), .twoWireSdaOut(twoWireSdaOut),
      .twoWireSclOut(twoWireSclOut), .d1PinIn(pinLevel[6]), .grpPinIn(pinLevel[5:0]),
      .d1PinOut(d1PinOut), .d1PinOe(d1PinOe), .d1PinPullup(d1PinPullup),
      .d1PinHighDrive(d1PinHighDrive), .d1Capture(d1Capture), .d1PortIn(d1PortIn),
      .d1Mode(d1Mode), .grpPinOut(grpPinOut), .grpPinOe(grpPinOe), .grpPinPullup(grpPinPullup),
      .grpPortIn(grpPortIn), .int2Input(int2Input), .serialDataIn(serialDataIn),
      .serialCsIn(serialCsIn), .serialClkIn(serialClkIn),
      .twoWireSdaIn(twoWireSdaIn), .twoWireSclIn(twoWireSclIn));

   ppfs_board_model board_u (.sys_clk(sys_clk), .pinOut({d1PinOut, grpPinOut}),
      .pinOe({d1PinOe, grpPinOe}), .pinPullup({d1PinPullup, grpPinPullup}), .extEn(extEn),
      .extVal(extVal), .pinLevel(pinLevel));

   // ----------------------------
   // Helpers
   // ----------------------------
   task automatic wrap_up;
      $display("Counts: %0d compares, %0d mismatches", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : wrap_up

   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      comparisons++;
      if (got !== exp)
      begin
         failures++;
         $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk

   // Negative results: -2 pin is input but mode ambiguous, -1 combination undefined
   function automatic int expMode(input ppfs_d1_cfg_s c);
      logic [1:0] cmb;
      logic [2:0] iod;
      logic tmr;
      logic en;
      cmb = {c.combination_mode_hi, c.combination_mode_lo};
      iod = {c.chan_d_io_ctrl_2, c.chan_d_io_ctrl_1, c.chan_d_io_ctrl_0};
      tmr = cmb == 2'h0 && c.selector_a && !c.chan_d1_pwm_mode;
      en = !c.chan_d1_output_disable;
      if (en && cmb[1])
         return PPFS_COMPL;
      if (en && cmb == 2'h1)
         return PPFS_RESYNC;
      if (en && cmb == 2'h0 && c.selector_a && c.chan_d1_pwm_mode)
         return PPFS_PWM;
      if (en && tmr && iod inside {3'h1, 3'h2, 3'h3})
         return PPFS_COMPARE;
      if (tmr && iod[2] && !c.p2_pin7_direction)
         return en ? int'(PPFS_CAPTURE) : -2;
      if (en)
         return -1;
      return c.p2_pin7_direction ? PPFS_GPIO_OUT : PPFS_GPIO_IN;
   endfunction : expMode

   task automatic d1Step(input ppfs_d1_cfg_s c);
      int m;
      logic oeExp;
      logic outExp;
      @(posedge sys_clk);
      d1Cfg <= c;
      grpCfg.pullup_ctrl_5 <= 1'($random(seed));
      {portD1Data, complPwm, resyncPwm, pwmWave, compareWave, extVal[6]} <= 6'($random(seed));
      repeat (5) @(posedge sys_clk);
      #1;
      m = expMode(c);
      oeExp = m inside {PPFS_GPIO_OUT, PPFS_COMPL, PPFS_RESYNC, PPFS_PWM, PPFS_COMPARE};
      case (m)
         PPFS_COMPL: outExp = complPwm;
         PPFS_RESYNC: outExp = resyncPwm;
         PPFS_PWM: outExp = pwmWave;
         PPFS_COMPARE: outExp = compareWave;
         default: outExp = portD1Data;
      endcase
      if (m >= 0)
         chk(8'(d1Mode), 8'(m), "mode");
      if (m != -1)
      begin
         chk(8'(d1PinOe), 8'(oeExp), "oe");
         chk(8'(d1PinHighDrive), 8'(c.p2_pin7_drive_strength & oeExp), "drive");
         chk(8'(d1PinPullup), 8'(grpCfg.pullup_ctrl_5 & !oeExp), "d1 pullup");
      end
      if (oeExp)
         chk(8'(d1PinOut), 8'(outExp), "d1 out");
      if (m == PPFS_CAPTURE)
         chk(8'(d1Capture), 8'(extVal[6]), "capture");
      if (m == PPFS_GPIO_IN)
         chk(8'(d1PortIn), 8'(extVal[6]), "port in");
   endtask : d1Step

   task automatic grpStep(input ppfs_grp_cfg_s g, input logic [5:0] oeExp,
      input logic [5:0] outExp, input logic [5:0] mask);
      @(posedge sys_clk);
      grpCfg <= g;
      repeat (5) @(posedge sys_clk);
      #1;
      chk(8'(grpPinOe), 8'(oeExp), "grp oe");
      chk(8'(grpPinOut & mask & oeExp), 8'(outExp & mask & oeExp), "grp out");
      chk(8'(grpPinPullup), 8'({{2{g.pullup_ctrl_7}}, {4{g.pullup_ctrl_6}}} & ~oeExp),
         "grp pullup");
   endtask : grpStep

   // ----------------------------
   // Clock, timeout, sequence
   // ----------------------------
   initial
   begin
      sys_clk = 1'h0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   always @(posedge sys_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 5000)
      begin
         failures++;
         wrap_up();
      end
   end

   initial
   begin
      ppfs_grp_cfg_s g;
      logic [2:0] pd;
      logic [3:0] ev;
      sys_rst = 1'h1;
      d1Cfg = '0;
      grpCfg = '0;
      {portD1Data, complPwm, resyncPwm, pwmWave, compareWave, timerAWave, timerBWave} = '0;
      {serialDataOut, serialCsOut, serialClkOut} = '0;
      portGrpData = '0;
      {twoWireSdaOut, twoWireSclOut} = '0;
      extEn = 7'h40;
      extVal = 7'h00;
      repeat (3) @(posedge sys_clk);
      sys_rst <= 1'h0;
      foreach (corner[i])
         d1Step(corner[i]);
      repeat (300)
         d1Step(10'($random(seed)));
      $display("Channel pin selection test done");
      repeat (40)
      begin
         g = '0;
         g.dir = 6'($random(seed));
         {g.pullup_ctrl_6, g.pullup_ctrl_7} = 2'($random(seed));
         pd = 3'($random(seed));
         portGrpData <= pd;
         grpStep(g, g.dir, {pd, pd}, 6'h3F);
      end
      g = '0;
      g.timerAOutEn = 1'h1;
      g.timerBMode = 2'h2;
      g.pullup_ctrl_6 = 1'h1;
      {timerAWave, timerBWave} <= 2'h3;
      grpStep(g, 6'h03, 6'h03, 6'h03);
      for (int od = 0; od < 2; od++)
         for (int v = 0; v < 2; v++)
         begin
            g = '0;
            g.dataOutCtl = 1'h1;
            g.csSel = 2'h2;
            g.clkOutCtl = 1'h1;
            g.data_pin_open_drain_sel = od[0];
            g.chip_select_open_drain_sel = od[0];
            g.clock_pin_open_drain_sel = od[0];
            {serialDataOut, serialCsOut, serialClkOut} <= {3{v[0]}};
            grpStep(g, (od && v) ? 6'h00 : 6'h38, (od || !v) ? 6'h00 : 6'h38, 6'h38);
         end
      $display("Group pin selection test done");
      g = '0;
      g.dataInCtl = 1'h1;
      g.csSel = 2'h1;
      g.clkInCtl = 1'h1;
      g.int2En = 1'h1;
      g.int2Sel = 1'h1;
      g.pullup_ctrl_7 = 1'h1;
      repeat (8)
      begin
         ev = 4'($random(seed));
         extEn <= 7'h7C;
         extVal[5:2] <= ev;
         grpStep(g, 6'h00, 6'h00, 6'h00);
         chk(8'({serialClkIn, serialCsIn, serialDataIn, int2Input}), 8'(ev), "serial in");
         chk(8'(grpPortIn[5:2]), 8'(ev), "grp port in");
      end
      g = '0;
      g.twoWireSel = 1'h1;
      g.twoWireEn = 1'h1;
      extVal[5:4] <= 2'h3;
      for (int v = 0; v < 4; v++)
      begin
         {twoWireSclOut, twoWireSdaOut} <= 2'(v);
         grpStep(g, {~2'(v), 4'h0}, 6'h00, 6'h30);
         chk(8'({twoWireSclIn, twoWireSdaIn}), 8'(v), "two-wire in");
      end
      $display("Group input test done");
      wrap_up();
   end
endmodule : port_pin_function_select_tb
